// *** verilog/psl_pkg.sv ***
// constants, field layout and lock states of the port set/clear and lock block
// assumes an apb4 master with byte strobes and a single 10 MHz clock
// Overview of operation
// - a 1 in a bit of the low set field of the set/clear register sets that output latch bit.
// - a 1 in a bit of the clear field [23:16] of the set/clear register clears that latch bit.
// - when one write asks to set and to clear the same bit, the bit is set.
// - a 1 in the low eight bits of the clear-only register clears that latch bit.
// - the lock key bit can always be read and shows 1 only while the lock is in effect.
// - the lock is armed by writing key 1, 0, 1 and then one read, which returns 0; reads after that return 1.
// - any step out of order or with a wrong value leaves the lock inactive.
// - once locked, the protected pin configuration cannot change until the next reset.
// - a per-pin lock bit at 1 protects that pin's fields in the configuration registers.
// - the per-pin lock bits are writable only while the key is inactive and then hold.
// - in output modes with cnf 00 each latch bit drives its pin, so writes change pins directly; cnf 01 drives only zeros, cnf 1x leaves the pin undriven.
package psl_pkg;
    localparam int unsigned PINS = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned LANE_W = 8;
    localparam int unsigned NIB_W = 4;
    // register byte offsets
    localparam logic [11:0] OFS_CFG_LOW = 12'h000;
    localparam logic [11:0] OFS_CFG_HIGH = 12'h004;
    localparam logic [11:0] OFS_INPUT = 12'h008;
    localparam logic [11:0] OFS_OUTPUT = 12'h00C;
    localparam logic [11:0] OFS_SET_CLEAR = 12'h010;
    localparam logic [11:0] OFS_CLEAR_ONLY = 12'h014;
    localparam logic [11:0] OFS_LOCK = 12'h018;
    // reset values
    localparam logic [31:0] RST_CFG_LOW = 32'h44444444;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_LOCK_BITS = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    // byte lanes and bit positions
    localparam int unsigned SET_LANE = 0;
    localparam int unsigned KEY_LANE = 1;
    localparam int unsigned CLR_LANE = 2;
    localparam int unsigned LOCK_LANE = 0;
    localparam int unsigned SET_LSB = 0;
    localparam int unsigned CLR_LSB = 16;
    localparam int unsigned KEY_BIT = 8;
    localparam int unsigned LOCK_LSB = 0;
    // configuration nibble: mode [1:0], cnf [3:2]
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned CNF_OD_BIT = 2;
    localparam int unsigned CNF_ALT_BIT = 3;
    localparam logic [1:0] MODE_INPUT = 2'h0;
    typedef enum logic [2:0] {
        LK_IDLE,
        LK_WROTE1,
        LK_WROTE0,
        LK_WROTE1B,
        LK_ACTIVE
    } psl_lock_state_t;
endpackage

// *** verilog/psl_port_ctrl.sv ***
// apb slave for an 8-pin port: config, input, output latch, set/clear, clear-only, lock
// assumes synchronous inputs on mclk_in, a zero-wait-capable apb4 master, pins resolved outside
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module psl_port_ctrl (
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    // port state towards the rest of the port
    output logic [7:0] output_latch_out,
    output logic [31:0] pin_config_low_out,
    output logic [7:0] pin_lock_bits_out,
    output logic lock_active_out
);

    // merge write data into a word, byte lane by byte lane
    function automatic logic [31:0] psl_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < psl_pkg::STRB_W; i++) begin
            if (strb[i]) begin
                res[i*psl_pkg::LANE_W +: psl_pkg::LANE_W] =
                    new_val[i*psl_pkg::LANE_W +: psl_pkg::LANE_W];
            end
        end
        return res;
    endfunction

    // one byte lane of the write data, zero when its strobe is low
    function automatic logic [7:0] psl_lane(
        input logic [31:0] data,
        input logic [3:0] strb,
        input int unsigned lane
    );
        logic [7:0] res;
        res = strb[lane] ? data[lane*psl_pkg::LANE_W +: psl_pkg::LANE_W] : 8'h00;
        return res;
    endfunction

    // address decode
    function automatic logic psl_mapped(input logic [11:0] addr);
        logic hit;
        hit = (addr == psl_pkg::OFS_CFG_LOW) || (addr == psl_pkg::OFS_CFG_HIGH) ||
              (addr == psl_pkg::OFS_INPUT) || (addr == psl_pkg::OFS_OUTPUT) ||
              (addr == psl_pkg::OFS_SET_CLEAR) || (addr == psl_pkg::OFS_CLEAR_ONLY) ||
              (addr == psl_pkg::OFS_LOCK);
        return hit;
    endfunction

    // registers
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pslverr_q;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [7:0] lock_bits_q;
    logic [7:0] lock_bits_d;
    logic [7:0] input_q;
    logic [7:0] pin_q;
    logic [7:0] pin_oe_q;
    logic [7:0] pin_d;
    logic [7:0] pin_oe_d;
    psl_pkg::psl_lock_state_t lock_state_q;
    psl_pkg::psl_lock_state_t lock_state_d;
    logic lock_active_q;

    // access strobes
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic addr_ok;
    logic wr_cfg_low;
    logic wr_output;
    logic wr_set_clear;
    logic wr_clear_only;
    logic wr_lock;
    logic rd_lock;
    logic [7:0] set_bits;
    logic [7:0] clear_bits;
    logic [7:0] pin_lock_new;
    logic key_new;
    logic [31:0] cfg_protect;

    assign setup_phase = psel_in && !penable_in;
    assign access_done = psel_in && penable_in && pready_q;
    assign addr_ok = psl_mapped(paddr_in);
    assign wr_done = access_done && pwrite_in && addr_ok;
    assign rd_done = access_done && !pwrite_in && addr_ok;
    assign wr_cfg_low = wr_done && (paddr_in == psl_pkg::OFS_CFG_LOW);
    assign wr_output = wr_done && (paddr_in == psl_pkg::OFS_OUTPUT);
    assign wr_set_clear = wr_done && (paddr_in == psl_pkg::OFS_SET_CLEAR);
    assign wr_clear_only = wr_done && (paddr_in == psl_pkg::OFS_CLEAR_ONLY);
    assign wr_lock = wr_done && (paddr_in == psl_pkg::OFS_LOCK);
    assign rd_lock = rd_done && (paddr_in == psl_pkg::OFS_LOCK);

    // ready one cycle after setup, error flag for unmapped addresses
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase && !addr_ok;
        end
    end

    // write data fields for the set, clear and lock registers
    always_comb begin
        set_bits = 8'h00;
        clear_bits = 8'h00;
        if (wr_set_clear) begin
            set_bits = psl_lane(pwdata_in, pstrb_in, psl_pkg::SET_LANE);
            clear_bits = psl_lane(pwdata_in, pstrb_in, psl_pkg::CLR_LANE);
        end else if (wr_clear_only) begin
            clear_bits = psl_lane(pwdata_in, pstrb_in, psl_pkg::SET_LANE);
        end
        pin_lock_new = pstrb_in[psl_pkg::LOCK_LANE] ?
            pwdata_in[psl_pkg::LOCK_LSB +: psl_pkg::PINS] : lock_bits_q;
        key_new = pstrb_in[psl_pkg::KEY_LANE] && pwdata_in[psl_pkg::KEY_BIT];
    end

    // output latch: direct writes, or set and clear with set winning
    always_comb begin
        latch_d = latch_q;
        if (wr_output) begin
            latch_d = psl_lane(pwdata_in, pstrb_in, psl_pkg::SET_LANE) |
                      (pstrb_in[psl_pkg::SET_LANE] ? 8'h00 : latch_q);
        end else begin
            latch_d = (latch_q & ~clear_bits) | set_bits;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            latch_q <= psl_pkg::RST_LATCH;
        end else begin
            latch_q <= latch_d;
        end
    end

    // lock key sequence
    always_comb begin
        lock_state_d = lock_state_q;
        lock_bits_d = lock_bits_q;
        unique case (lock_state_q)
            psl_pkg::LK_IDLE: begin
                if (wr_lock) begin
                    lock_bits_d = pin_lock_new;
                    lock_state_d = key_new ? psl_pkg::LK_WROTE1 : psl_pkg::LK_IDLE;
                end
            end
            psl_pkg::LK_WROTE1: begin
                if (wr_lock) begin
                    if (!key_new && pin_lock_new == lock_bits_q) begin
                        lock_state_d = psl_pkg::LK_WROTE0;
                    end else begin
                        lock_bits_d = pin_lock_new;
                        lock_state_d = key_new ? psl_pkg::LK_WROTE1 : psl_pkg::LK_IDLE;
                    end
                end else if (rd_lock) begin
                    lock_state_d = psl_pkg::LK_IDLE;
                end
            end
            psl_pkg::LK_WROTE0: begin
                if (wr_lock) begin
                    if (key_new && pin_lock_new == lock_bits_q) begin
                        lock_state_d = psl_pkg::LK_WROTE1B;
                    end else begin
                        lock_bits_d = pin_lock_new;
                        lock_state_d = key_new ? psl_pkg::LK_WROTE1 : psl_pkg::LK_IDLE;
                    end
                end else if (rd_lock) begin
                    lock_state_d = psl_pkg::LK_IDLE;
                end
            end
            psl_pkg::LK_WROTE1B: begin
                if (wr_lock) begin
                    lock_bits_d = pin_lock_new;
                    lock_state_d = key_new ? psl_pkg::LK_WROTE1 : psl_pkg::LK_IDLE;
                end else if (rd_lock) begin
                    lock_state_d = psl_pkg::LK_ACTIVE;
                end
            end
            psl_pkg::LK_ACTIVE: begin
                lock_state_d = psl_pkg::LK_ACTIVE;
            end
            default: begin
                lock_state_d = psl_pkg::LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            lock_state_q <= psl_pkg::LK_IDLE;
            lock_bits_q <= psl_pkg::RST_LOCK_BITS;
        end else begin
            lock_state_q <= lock_state_d;
            lock_bits_q <= lock_bits_d;
        end
    end

    // lock flag registered alongside the state for the output port
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            lock_active_q <= 1'b0;
        end else begin
            lock_active_q <= (lock_state_d == psl_pkg::LK_ACTIVE);
        end
    end

    // per-pin protection mask over the configuration nibbles
    generate
        for (genvar g = 0; g < psl_pkg::PINS; g++) begin : g_protect
            assign cfg_protect[g*psl_pkg::NIB_W +: psl_pkg::NIB_W] =
                {psl_pkg::NIB_W{(lock_state_q == psl_pkg::LK_ACTIVE) && lock_bits_q[g]}};
        end
    endgenerate

    // configuration register, locked nibbles keep their value
    always_comb begin
        cfg_d = cfg_q;
        if (wr_cfg_low) begin
            cfg_d = (psl_merge(cfg_q, pwdata_in, pstrb_in) & ~cfg_protect) |
                    (cfg_q & cfg_protect);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cfg_q <= psl_pkg::RST_CFG_LOW;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // input sampling
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            input_q <= 8'h00;
        end else begin
            input_q <= pin_in;
        end
    end

    // pin drive from the next latch and configuration values
    generate
        for (genvar p = 0; p < psl_pkg::PINS; p++) begin : g_pin
            logic [3:0] nib;
            logic out_mode;
            assign nib = cfg_d[p*psl_pkg::NIB_W +: psl_pkg::NIB_W];
            assign out_mode = (nib[psl_pkg::MODE_LSB +: 2] != psl_pkg::MODE_INPUT) &&
                              !nib[psl_pkg::CNF_ALT_BIT];
            always_comb begin
                if (!out_mode) begin
                    pin_d[p] = 1'b0;
                    pin_oe_d[p] = 1'b0;
                end else if (nib[psl_pkg::CNF_OD_BIT]) begin
                    pin_d[p] = 1'b0;
                    pin_oe_d[p] = !latch_d[p];
                end else begin
                    pin_d[p] = latch_d[p];
                    pin_oe_d[p] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pin_q <= 8'h00;
            pin_oe_q <= 8'h00;
        end else begin
            pin_q <= pin_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // read data captured in the setup cycle
    always_comb begin
        prdata_d = psl_pkg::ZERO_WORD;
        unique case (paddr_in)
            psl_pkg::OFS_CFG_LOW: begin
                prdata_d = cfg_q;
            end
            psl_pkg::OFS_INPUT: begin
                prdata_d[psl_pkg::SET_LSB +: psl_pkg::PINS] = input_q;
            end
            psl_pkg::OFS_OUTPUT: begin
                prdata_d[psl_pkg::SET_LSB +: psl_pkg::PINS] = latch_q;
            end
            psl_pkg::OFS_LOCK: begin
                prdata_d[psl_pkg::LOCK_LSB +: psl_pkg::PINS] = lock_bits_q;
                prdata_d[psl_pkg::KEY_BIT] = (lock_state_q == psl_pkg::LK_ACTIVE);
            end
            default: begin
                prdata_d = psl_pkg::ZERO_WORD;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            prdata_q <= psl_pkg::ZERO_WORD;
        end else if (setup_phase && !pwrite_in) begin
            prdata_q <= prdata_d;
        end
    end

    // outputs
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign pin_out = pin_q;
    assign pin_oe_out = pin_oe_q;
    assign output_latch_out = latch_q;
    assign pin_config_low_out = cfg_q;
    assign pin_lock_bits_out = lock_bits_q;
    assign lock_active_out = lock_active_q;

endmodule

// *** testbench/psl_port_ctrl_checker.sv ***
// assertions on the port set/clear and lock block
// assumes a bind onto psl_port_ctrl, one clock, synchronous reset
`timescale 1ns/10ps
module psl_port_ctrl_checker (
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // port state
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_out,
    input wire logic [7:0] output_latch_out,
    input wire logic [31:0] pin_config_low_out,
    input wire logic [7:0] pin_lock_bits_out,
    input wire logic lock_active_out
);
    logic acc;
    logic wr_sc;
    logic [31:0] lk_mask;
    assign acc = psel_in && penable_in && pready_out;
    assign wr_sc = acc && pwrite_in && (paddr_in == psl_pkg::OFS_SET_CLEAR);
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            lk_mask[4*p +: 4] = {4{pin_lock_bits_out[p]}};
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);
    property p_set;
        wr_sc && pstrb_in[0] |=>
            (output_latch_out & $past(pwdata_in[7:0])) == $past(pwdata_in[7:0]);
    endproperty
    property p_clr;
        wr_sc && pstrb_in == 4'hC |=> (output_latch_out & $past(pwdata_in[23:16])) == 8'h00;
    endproperty
    property p_clo;
        acc && pwrite_in && paddr_in == psl_pkg::OFS_CLEAR_ONLY && pstrb_in[0] |=>
            (output_latch_out & $past(pwdata_in[7:0])) == 8'h00;
    endproperty
    property p_keep;
        wr_sc && pstrb_in == 4'hF |=> ((output_latch_out ^ $past(output_latch_out)) &
            ~($past(pwdata_in[7:0]) | $past(pwdata_in[23:16]))) == 8'h00;
    endproperty
    property p_rdy;
        psel_in && !penable_in |=> pready_out ##1 !pready_out;
    endproperty
    property p_err;
        psel_in && !penable_in && paddr_in > psl_pkg::OFS_LOCK |=> pslverr_out;
    endproperty
    property p_key;
        acc && !pwrite_in && paddr_in == psl_pkg::OFS_LOCK |-> prdata_out[8] == lock_active_out;
    endproperty
    property p_stick;
        lock_active_out |=> lock_active_out && $stable(pin_lock_bits_out);
    endproperty
    property p_cfg;
        lock_active_out |=> ((pin_config_low_out ^ $past(pin_config_low_out)) & lk_mask) == 0;
    endproperty
    property p_pp;
        pin_config_low_out[15:12] == 4'h1 |-> pin_out[3] == output_latch_out[3] && pin_oe_out[3];
    endproperty
    a_set: assert property (p_set) else $error("set field not applied");
    a_clr: assert property (p_clr) else $error("clear field not applied");
    a_clo: assert property (p_clo) else $error("clear-only not applied");
    a_keep: assert property (p_keep) else $error("untouched latch bit changed");
    a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
    a_err: assert property (p_err) else $error("no error on unmapped address");
    a_key: assert property (p_key) else $error("key bit differs from lock state");
    a_stick: assert property (p_stick) else $error("lock or lock bits changed");
    a_cfg: assert property (p_cfg) else $error("locked config changed");
    a_pp: assert property (p_pp) else $error("pin not driven from latch");
    c_lock: cover property ($rose(lock_active_out));
    c_both: cover property (wr_sc && (pwdata_in[7:0] & pwdata_in[23:16]) != 8'h00);
    c_err: cover property (pslverr_out);
endmodule

// *** testbench/psl_port_ctrl_test.sv ***
// self-checking bench for the port set/clear and lock block
// assumes the design package is compiled first; the bench is the apb master
`timescale 1ns/10ps
module psl_port_ctrl_test;
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h00000000;
    logic [3:0] pstrb_in = 4'h0;
    logic [7:0] pin_in = 8'h5A;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_out;
    logic [7:0] output_latch_out;
    logic [31:0] pin_config_low_out;
    logic [7:0] pin_lock_bits_out;
    logic lock_active_out;
    logic [31:0] rd;
    logic er;
    int n_errors = 0;
    int num_checks = 0;
    psl_port_ctrl i_dut (.mclk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .pin_in, .pin_out,
        .pin_oe_out, .output_latch_out, .pin_config_low_out, .pin_lock_bits_out,
        .lock_active_out);
    always #50 mclk_in = ~mclk_in;
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (pready_out !== 1'b1) begin
            chk("pready", 32'h00000001, 32'(pready_out));
            end_of_test();
        end else begin
            rd = prdata_out;
            er = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
            @(negedge mclk_in);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(a, 1'b1, d, s);
    endtask
    task automatic rdr(input logic [11:0] a);
        xfer(a, 1'b0, 32'h00000000, 4'h0);
    endtask
    task automatic t_reset();
        @(posedge mclk_in);
        srst_in <= 1'b1;
        repeat (5) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(negedge mclk_in);
    endtask
    task automatic t_rst_vals();
        chk("config", 32'h44444444, pin_config_low_out);
        rdr(psl_pkg::OFS_LOCK);
        chk("lock read", 32'h00000000, rd);
        rdr(psl_pkg::OFS_SET_CLEAR);
        chk("set/clear read", 32'h00000000, rd);
        rdr(psl_pkg::OFS_INPUT);
        chk("input read", 32'h0000005A, rd);
    endtask
    task automatic t_setclr();
        wr(psl_pkg::OFS_OUTPUT, 32'h000000A5, 4'h1);
        wr(psl_pkg::OFS_SET_CLEAR, 32'h003C000F, 4'hF);
        chk("latch both", 32'h0000008F, 32'(output_latch_out));
        wr(psl_pkg::OFS_SET_CLEAR, 32'h00810000, 4'hC);
        chk("latch clear", 32'h0000000E, 32'(output_latch_out));
        wr(psl_pkg::OFS_SET_CLEAR, 32'h00FF0030, 4'h3);
        chk("latch set", 32'h0000003E, 32'(output_latch_out));
    endtask
    task automatic t_clronly();
        wr(psl_pkg::OFS_CLEAR_ONLY, 32'hFFFFFF06, 4'h3);
        chk("latch clear-only", 32'h00000038, 32'(output_latch_out));
        rdr(psl_pkg::OFS_CLEAR_ONLY);
        chk("clear-only read", 32'h00000000, rd);
    endtask
    task automatic t_pins();
        wr(psl_pkg::OFS_CFG_LOW, 32'h49541444, 4'hF);
        chk("pin level", 32'h00000008, 32'(pin_out & 8'h28));
        chk("pin enable", 32'h00000008, 32'(pin_oe_out & 8'h69));
        wr(psl_pkg::OFS_SET_CLEAR, 32'h00280000, 4'hC);
        chk("pin cleared", 32'h00000000, 32'(pin_out & 8'h28));
        chk("pin drain drive", 32'h00000028, 32'(pin_oe_out & 8'h69));
    endtask
    task automatic t_badlock();
        wr(psl_pkg::OFS_LOCK, 32'h00000108, 4'h3);
        wr(psl_pkg::OFS_LOCK, 32'h00000008, 4'h3);
        wr(psl_pkg::OFS_LOCK, 32'h00000008, 4'h3);
        rdr(psl_pkg::OFS_LOCK);
        chk("bad key read", 32'h00000008, rd);
        chk("bad lock state", 32'h00000000, 32'(lock_active_out));
    endtask
    task automatic t_lock();
        wr(psl_pkg::OFS_LOCK, 32'h00000108, 4'h3);
        wr(psl_pkg::OFS_LOCK, 32'h00000008, 4'h3);
        wr(psl_pkg::OFS_LOCK, 32'h00000108, 4'h3);
        rdr(psl_pkg::OFS_LOCK);
        chk("key first read", 32'h00000008, rd);
        rdr(psl_pkg::OFS_LOCK);
        chk("key second read", 32'h00000108, rd);
        chk("lock state", 32'h00000001, 32'(lock_active_out));
    endtask
    task automatic t_locked();
        wr(psl_pkg::OFS_CFG_LOW, 32'h00000000, 4'hF);
        chk("locked config", 32'h00001000, pin_config_low_out);
        wr(psl_pkg::OFS_LOCK, 32'h000000FF, 4'h3);
        chk("lock bits", 32'h00000008, 32'(pin_lock_bits_out));
        rdr(psl_pkg::OFS_LOCK);
        chk("key held", 32'h00000108, rd);
    endtask
    task automatic t_unmapped();
        rdr(12'h01C);
        chk("unmapped error", 32'h00000001, 32'(er));
        chk("unmapped data", 32'h00000000, rd);
    endtask
    task automatic t_relock();
        t_reset();
        chk("lock after reset", 32'h00000000, 32'(lock_active_out));
        chk("config after reset", 32'h44444444, pin_config_low_out);
        wr(psl_pkg::OFS_LOCK, 32'h0000000F, 4'h1);
        chk("lock bits free", 32'h0000000F, 32'(pin_lock_bits_out));
    endtask
    initial begin
        t_reset();
        t_rst_vals();
        t_setclr();
        t_clronly();
        t_pins();
        t_badlock();
        t_lock();
        t_locked();
        t_unmapped();
        t_relock();
        end_of_test();
    end
endmodule
bind psl_port_ctrl psl_port_ctrl_checker i_chk (.mclk_in, .srst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
    .pin_out, .pin_oe_out, .output_latch_out, .pin_config_low_out, .pin_lock_bits_out,
    .lock_active_out);
